// >>> src/smpio_spi_slave.sv
// SPI slave for memory reads and port pin access
//
// Contract
// - Read sends status byte, then target data
// - Reserved addresses read as zero
// - Pointer advances per byte; reads wrap to zero, writes wrap to A_OST_LO
// - Chip select rising ends the transfer
// - After status write, read forces upper region
// - Clock reads come from address-time snapshot
// - Port read addresses alternate with each other
// - Nonexistent addresses read zero until wrap
// - Power-up loads defaults, pins tristated meanwhile
// - Input pins keep their driver off
// - High-current mode bit makes pins switch sequentially
// - High-current config changes wait for port write
// - Port writes need write enable latch set
// - Low-current group switches on next falling edge
// - Low-current write at first address loops groups
// - In mode (1,1) the last byte applies at chip select rising
// - High-current pins tristate in turn from 0/8
// - Extra gap between pin 7 and 8
// - High-current writes increment, never alternate groups
// - Pins sampled on previous byte's LSB edge
// - Low group pin 7 first; high group zero-padded
// - Low-current output-state writes toggle, else increment
// - Write enable clears after a real write or a write disable command
`timescale 1ns/1ns
`default_nettype none
module smpio_spi_slave import smpio_pkg::*; #(
	parameter int POIP_NS = POIP_NS_DEF
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Serial link pins
	input wire logic sck,
	input wire logic chip_select_low,
	input wire logic si,
	output logic so_out,
	output logic so_oe,
	// Port pins
	input wire logic [11:0] port_pin_in,
	output logic [11:0] port_pin_out,
	output logic [11:0] port_pin_oe,
	// Rest of the device
	input wire smpio_cfg_t pin_defaults,
	input wire logic [7:0] status_in,
	input wire logic [55:0] rtc_live,
	output logic [8:0] mem_rd_addr,
	input wire logic [7:0] mem_rd_data,
	// Block state
	output logic write_enable,
	output logic high_current_mode,
	output logic init_busy
);
	localparam int POIP_CYC = (POIP_NS + CLK_NS - 1) / CLK_NS;
	localparam int PW = $clog2(POIP_CYC + 1);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic in_rng(input logic [8:0] a, input logic [8:0] lo, input logic [8:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction

	function automatic logic [8:0] next_ptr(input logic [8:0] p, input logic tog, input logic [8:0] wrap);
		if (tog) begin
			return {p[8:1], ~p[0]};
		end else if (p == A_LAST) begin
			return wrap;
		end else begin
			return p + 9'h001;
		end
	endfunction

	function automatic logic opc_is(input logic [7:0] b, input logic [7:0] opc);
		return (b & ~OPC_UA_MASK) == opc;
	endfunction

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [SYNC_W-1:0] s1_q, s2_q, s3_q, filt_q, filt_d;
	logic sck_rise, sck_fall, cs_fall, cs_rise;
	logic [PW-1:0] poip_q, poip_d;
	logic busy_q;
	logic refresh;
	smpio_cfg_t cfg_q, cfg_d;
	logic commit, hc_start, hc_hi;
	logic [11:0] tri_mask, load_mask;
	logic [11:0] act_st_q, act_st_d, act_dir_q, act_dir_d, act_od_q, act_od_d;
	logic [11:0] pin_out_d, pin_oe_d, pins_now;
	smpio_phase_t phase_q, phase_d;
	logic [2:0] bit_q, bit_d;
	logic [7:0] sh_in_q, sh_in_d, rx_byte;
	logic ua_q, ua_d, rd_q, rd_d, tog_q, tog_d;
	logic [8:0] ptr_q, ptr_d, rtc_off;
	logic wr_any_q, wr_any_d, wen_q, wen_d, stw_q, stw_d;
	logic [7:0] nxt_q, nxt_d, rd_byte, st_byte;
	logic load_q, load_d;
	logic [55:0] snap_q, snap_d;
	logic wp_q, wp_d;
	logic [8:0] wa_q, wa_d;
	logic [7:0] wdat_q, wdat_d, so_sh_q, so_sh_d;
	logic so_q, so_d, so_oe_q, so_oe_d;

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	// A change counts once the second and third stages agree
	always_comb begin
		filt_d = (s2_q & s3_q) | (filt_q & (s2_q ^ s3_q));
		sck_rise = filt_d[IX_SCK] & ~filt_q[IX_SCK];
		sck_fall = ~filt_d[IX_SCK] & filt_q[IX_SCK];
		cs_fall = ~filt_d[IX_CS] & filt_q[IX_CS];
		cs_rise = filt_d[IX_CS] & ~filt_q[IX_CS];
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s1_q <= SYNC_RST;
			s2_q <= SYNC_RST;
			s3_q <= SYNC_RST;
			filt_q <= SYNC_RST;
		end else begin
			s1_q <= {sck, chip_select_low, si, port_pin_in};
			s2_q <= s1_q;
			s3_q <= s2_q;
			filt_q <= filt_d;
		end
	end

	// ------------------------------------------------------------
	// Power-on initialisation timer
	// ------------------------------------------------------------
	// Restarted by reset and by the restore defaults command
	always_comb begin
		if (refresh) begin
			poip_d = PW'(POIP_CYC);
		end else if (poip_q != '0) begin
			poip_d = poip_q - PW'(1);
		end else begin
			poip_d = poip_q;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			poip_q <= PW'(POIP_CYC);
			busy_q <= 1'b1;
		end else begin
			poip_q <= poip_d;
			busy_q <= (poip_d != '0);
		end
	end

	// ------------------------------------------------------------
	// Port configuration registers
	// ------------------------------------------------------------
	// Staged byte lands on the next falling SCK, or on deselect in mode (1,1)
	always_comb begin
		cfg_d = cfg_q;
		commit = wp_q & (sck_fall | cs_rise);
		if (busy_q) begin
			cfg_d = pin_defaults;
		end else if (commit) begin
			if (wa_q == A_OST_LO) begin
				cfg_d.state[7:0] = wdat_q;
			end else if (wa_q == A_OST_HI) begin
				cfg_d.state[11:8] = wdat_q[3:0];
			end else if (wa_q == A_DIR_LO) begin
				cfg_d.dir[7:0] = wdat_q;
			end else if (wa_q == A_DIR_HI) begin
				cfg_d.dir[11:8] = wdat_q[3:0];
			end else if (wa_q == A_TYP_LO) begin
				cfg_d.odrain[7:0] = wdat_q;
			end else if (wa_q == A_MODE) begin
				cfg_d.hcm = wdat_q[MODE_HCM];
				cfg_d.rd_inv = wdat_q[MODE_INV];
				cfg_d.odrain[11:8] = wdat_q[MODE_TYP_HI +: 4];
			end
		end
		hc_start = commit & ~busy_q & cfg_q.hcm & (wa_q == A_OST_LO || wa_q == A_OST_HI);
		hc_hi = (wa_q == A_OST_HI);
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cfg_q <= '0;
		end else begin
			cfg_q <= cfg_d;
		end
	end

	// ------------------------------------------------------------
	// High-current sequencer
	// ------------------------------------------------------------
	smpio_hc_seq #(
		.TRI_CYC(HC_TRI_CYC),
		.GAP_CYC(HC_GAP_CYC)
	) u_seq (
		.mclk(mclk),
		.rst(rst),
		.start(hc_start),
		.start_hi(hc_hi),
		.tri_mask(tri_mask),
		.load_mask(load_mask)
	);

	// ------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------
	// Low-current mode follows the registers at once; high-current mode per walk step
	always_comb begin
		act_st_d = act_st_q;
		act_dir_d = act_dir_q;
		act_od_d = act_od_q;
		for (int i = 0; i < PIN_N; i++) begin
			if (busy_q || !cfg_q.hcm) begin
				act_st_d[i] = cfg_d.state[i];
				act_dir_d[i] = cfg_d.dir[i];
				act_od_d[i] = cfg_d.odrain[i];
			end else if (load_mask[i]) begin
				act_st_d[i] = cfg_q.state[i];
				act_dir_d[i] = cfg_q.dir[i];
				act_od_d[i] = cfg_q.odrain[i];
			end
		end
		// Drivers drop in the same cycle as init starts, not one later
		pin_oe_d = {PIN_N{(poip_d == '0)}} & ~tri_mask & act_dir_q & (~act_od_q | ~act_st_q);
		pin_out_d = act_st_q & ~act_od_q;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			act_st_q <= '0;
			act_dir_q <= '0;
			act_od_q <= '0;
			port_pin_out <= '0;
			port_pin_oe <= '0;
		end else begin
			act_st_q <= act_st_d;
			act_dir_q <= act_dir_d;
			act_od_q <= act_od_d;
			port_pin_out <= pin_out_d;
			port_pin_oe <= pin_oe_d;
		end
	end

	// ------------------------------------------------------------
	// Read data selection
	// ------------------------------------------------------------
	// Pins are taken on the edge that captures the previous byte's LSB
	always_comb begin
		pins_now = filt_q[11:0] ^ {PIN_N{cfg_q.rd_inv}};
		rtc_off = ptr_q - A_RTC_FIRST;
		st_byte = status_in;
		st_byte[STATUS_WEN] = wen_q;
		rx_byte = {sh_in_q[6:0], filt_d[IX_SI]};
		if (ptr_q > A_LAST) begin
			rd_byte = 8'h00;
		end else if (ptr_q == A_OST_LO) begin
			rd_byte = cfg_q.state[7:0];
		end else if (ptr_q == A_OST_HI) begin
			rd_byte = {4'h0, cfg_q.state[11:8]};
		end else if (ptr_q == A_DIR_LO) begin
			rd_byte = cfg_q.dir[7:0];
		end else if (ptr_q == A_DIR_HI) begin
			rd_byte = {4'h0, cfg_q.dir[11:8]};
		end else if (ptr_q == A_TYP_LO) begin
			rd_byte = cfg_q.odrain[7:0];
		end else if (ptr_q == A_MODE) begin
			rd_byte = {cfg_q.odrain[11:8], 2'h0, cfg_q.rd_inv, cfg_q.hcm};
		end else if (ptr_q == A_PIN_LO) begin
			rd_byte = pins_now[7:0];
		end else if (ptr_q == A_PIN_HI) begin
			rd_byte = {4'h0, pins_now[11:8]};
		end else if (ptr_q == A_RSVD) begin
			rd_byte = 8'h00;
		end else if (in_rng(ptr_q, A_RTC_FIRST, A_RTC_LAST)) begin
			rd_byte = snap_q[{rtc_off[2:0], 3'h0} +: 8];
		end else begin
			rd_byte = mem_rd_data;
		end
	end

	// ------------------------------------------------------------
	// Serial protocol engine
	// ------------------------------------------------------------
	always_comb begin
		phase_d = phase_q;
		bit_d = bit_q;
		sh_in_d = sh_in_q;
		ua_d = ua_q;
		rd_d = rd_q;
		tog_d = tog_q;
		ptr_d = ptr_q;
		wr_any_d = wr_any_q;
		wen_d = wen_q;
		stw_d = stw_q;
		nxt_d = nxt_q;
		load_d = load_q;
		snap_d = snap_q;
		wp_d = wp_q & ~commit;
		wa_d = wa_q;
		wdat_d = wdat_q;
		so_sh_d = so_sh_q;
		so_d = so_q;
		so_oe_d = so_oe_q;
		refresh = 1'b0;
		if (cs_fall) begin
			phase_d = PH_CMD;
			bit_d = BIT_FIRST;
			wr_any_d = 1'b0;
			load_d = 1'b0;
		end else if (cs_rise) begin
			phase_d = PH_IDLE;
			so_oe_d = 1'b0;
			if (phase_q == PH_WRITE && wr_any_q) begin
				wen_d = 1'b0;
			end
		end else if (sck_rise && phase_q != PH_IDLE && phase_q != PH_DONE) begin
			sh_in_d = rx_byte;
			bit_d = bit_q + 3'h1;
			if (bit_q == BIT_LAST) begin
				case (phase_q)
					PH_CMD: begin
						phase_d = PH_DONE;
						stw_d = opc_is(rx_byte, OPC_STWR);
						if (opc_is(rx_byte, OPC_READ) || opc_is(rx_byte, OPC_WRITE)) begin
							phase_d = PH_ADDR;
							rd_d = opc_is(rx_byte, OPC_READ);
							ua_d = stw_q | rx_byte[OPC_UA_BIT];
						end else if (opc_is(rx_byte, OPC_WENA)) begin
							wen_d = 1'b1;
						end else if (opc_is(rx_byte, OPC_WDIS)) begin
							wen_d = 1'b0;
						end else if (opc_is(rx_byte, OPC_RSTR)) begin
							refresh = 1'b1;
						end
					end
					PH_ADDR: begin
						ptr_d = {ua_q, rx_byte};
						if (rd_q) begin
							phase_d = PH_READ;
							nxt_d = st_byte;
							load_d = 1'b1;
							snap_d = rtc_live;
							tog_d = in_rng(ptr_d, A_PIN_LO, A_PIN_HI);
						end else begin
							phase_d = PH_WRITE;
							tog_d = ~cfg_q.hcm & in_rng(ptr_d, A_OST_LO, A_OST_HI);
						end
					end
					PH_READ: begin
						nxt_d = rd_byte;
						load_d = 1'b1;
						ptr_d = next_ptr(ptr_q, tog_q, A_ZERO);
					end
					PH_WRITE: begin
						if (wen_q && in_rng(ptr_q, A_OST_LO, A_MODE)) begin
							wp_d = 1'b1;
							wa_d = ptr_q;
							wdat_d = rx_byte;
							wr_any_d = 1'b1;
						end
						ptr_d = next_ptr(ptr_q, tog_q, A_OST_LO);
					end
					default: begin
					end
				endcase
			end
		end else if (sck_fall && phase_q == PH_READ) begin
			so_oe_d = 1'b1;
			if (load_q) begin
				so_sh_d = nxt_q;
				so_d = nxt_q[7];
				load_d = 1'b0;
			end else begin
				so_sh_d = {so_sh_q[6:0], 1'b0};
				so_d = so_sh_q[6];
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			phase_q <= PH_IDLE;
			bit_q <= BIT_FIRST;
			sh_in_q <= '0;
			ua_q <= 1'b0;
			rd_q <= 1'b0;
			tog_q <= 1'b0;
			ptr_q <= A_ZERO;
			wr_any_q <= 1'b0;
			wen_q <= 1'b0;
			stw_q <= 1'b0;
			nxt_q <= '0;
			load_q <= 1'b0;
			snap_q <= '0;
			wp_q <= 1'b0;
			wa_q <= A_ZERO;
			wdat_q <= '0;
			so_sh_q <= '0;
			so_q <= 1'b0;
			so_oe_q <= 1'b0;
		end else begin
			phase_q <= phase_d;
			bit_q <= bit_d;
			sh_in_q <= sh_in_d;
			ua_q <= ua_d;
			rd_q <= rd_d;
			tog_q <= tog_d;
			ptr_q <= ptr_d;
			wr_any_q <= wr_any_d;
			wen_q <= wen_d;
			stw_q <= stw_d;
			nxt_q <= nxt_d;
			load_q <= load_d;
			snap_q <= snap_d;
			wp_q <= wp_d;
			wa_q <= wa_d;
			wdat_q <= wdat_d;
			so_sh_q <= so_sh_d;
			so_q <= so_d;
			so_oe_q <= so_oe_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign so_out = so_q;
	assign so_oe = so_oe_q;
	assign mem_rd_addr = ptr_q;
	assign write_enable = wen_q;
	assign high_current_mode = cfg_q.hcm;
	assign init_busy = busy_q;

endmodule
`default_nettype wire

// >>> src/smpio_pkg.sv
// Package: constants and types of the SPI memory read and port pin block
package smpio_pkg;

	// ------------------------------------------------------------
	// Address map
	// ------------------------------------------------------------
	localparam int AW = 9;
	localparam logic [8:0] A_ZERO = 9'h000;
	localparam logic [8:0] A_LAST = 9'h135;
	localparam logic [8:0] A_OST_LO = 9'h120;
	localparam logic [8:0] A_OST_HI = 9'h121;
	localparam logic [8:0] A_DIR_LO = 9'h122;
	localparam logic [8:0] A_DIR_HI = 9'h123;
	localparam logic [8:0] A_TYP_LO = 9'h124;
	localparam logic [8:0] A_MODE = 9'h125;
	localparam logic [8:0] A_PIN_LO = 9'h126;
	localparam logic [8:0] A_PIN_HI = 9'h127;
	localparam logic [8:0] A_RSVD = 9'h128;
	localparam logic [8:0] A_RTC_FIRST = 9'h129;
	localparam logic [8:0] A_RTC_LAST = 9'h12F;
	localparam int RTC_BYTES = 7;

	// ------------------------------------------------------------
	// Mode register fields
	// ------------------------------------------------------------
	localparam int MODE_HCM = 0;
	localparam int MODE_INV = 1;
	localparam int MODE_TYP_HI = 4;

	// ------------------------------------------------------------
	// Command codes and status byte
	// ------------------------------------------------------------
	localparam logic [7:0] OPC_STWR = 8'h01;
	localparam logic [7:0] OPC_WRITE = 8'h02;
	localparam logic [7:0] OPC_READ = 8'h03;
	localparam logic [7:0] OPC_WDIS = 8'h04;
	localparam logic [7:0] OPC_WENA = 8'h06;
	localparam logic [7:0] OPC_RSTR = 8'h07;
	localparam int OPC_UA_BIT = 3;
	localparam logic [7:0] OPC_UA_MASK = 8'h08;
	localparam int STATUS_WEN = 1;

	// ------------------------------------------------------------
	// Pins, synchroniser layout, bit counter
	// ------------------------------------------------------------
	localparam int PIN_N = 12;
	localparam logic [3:0] PIN_FIRST_LO = 4'h0;
	localparam logic [3:0] PIN_LAST_LO = 4'h7;
	localparam logic [3:0] PIN_FIRST_HI = 4'h8;
	localparam logic [3:0] PIN_LAST_HI = 4'hB;
	localparam logic [11:0] PIN_ONE = 12'h001;
	localparam int SYNC_W = 15;
	localparam int IX_SCK = 14;
	localparam int IX_CS = 13;
	localparam int IX_SI = 12;
	localparam logic [14:0] SYNC_RST = 15'h2000;
	localparam logic [2:0] BIT_FIRST = 3'h0;
	localparam logic [2:0] BIT_LAST = 3'h7;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_NS = 50;
	localparam int POIP_NS_DEF = 1000;
	localparam int HC_TRI_NS = 2000;
	localparam int HC_GAP_NS = 1000;
	localparam int HC_TRI_CYC = (HC_TRI_NS / CLK_NS < 1) ? 1 : HC_TRI_NS / CLK_NS;
	localparam int HC_GAP_CYC = (HC_GAP_NS / CLK_NS < 1) ? 1 : HC_GAP_NS / CLK_NS;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [11:0] state;
		logic [11:0] dir;
		logic [11:0] odrain;
		logic hcm;
		logic rd_inv;
	} smpio_cfg_t;

	typedef enum logic [2:0] {PH_IDLE, PH_CMD, PH_ADDR, PH_READ, PH_WRITE, PH_DONE} smpio_phase_t;
	typedef enum logic [1:0] {SQ_IDLE, SQ_TRI, SQ_GAP} smpio_seq_t;

endpackage

// >>> src/smpio_hc_seq.sv
// High-current sequencer: tristates and reloads port pins one after another
`timescale 1ns/1ns
`default_nettype none
module smpio_hc_seq import smpio_pkg::*; #(
	parameter int TRI_CYC = HC_TRI_CYC,
	parameter int GAP_CYC = HC_GAP_CYC
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Start request
	input wire logic start,
	input wire logic start_hi,
	// Pin control
	output logic [11:0] tri_mask,
	output logic [11:0] load_mask
);
	localparam int CW = $clog2(TRI_CYC + GAP_CYC + 1);

	smpio_seq_t st_q, st_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic [3:0] pin_q, pin_d, last_q, last_d;
	logic all_q, all_d;
	logic [11:0] tri_d, load_d;

	// Next state of the pin walk
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		pin_d = pin_q;
		last_d = last_q;
		all_d = all_q;
		load_d = '0;
		tri_d = (st_q == SQ_TRI) ? (PIN_ONE << pin_q) : '0;
		case (st_q)
			SQ_TRI: begin
				if (cnt_q == CW'(1)) begin
					load_d = PIN_ONE << pin_q;
					if (pin_q == last_q) begin
						st_d = SQ_IDLE;
					end else if (pin_q == PIN_LAST_LO && all_q) begin
						st_d = SQ_GAP;
						cnt_d = CW'(GAP_CYC);
					end else begin
						pin_d = pin_q + 4'h1;
						cnt_d = CW'(TRI_CYC);
					end
				end else begin
					cnt_d = cnt_q - CW'(1);
				end
			end
			SQ_GAP: begin
				if (cnt_q == CW'(1)) begin
					st_d = SQ_TRI;
					pin_d = pin_q + 4'h1;
					cnt_d = CW'(TRI_CYC);
				end else begin
					cnt_d = cnt_q - CW'(1);
				end
			end
			default: begin
			end
		endcase
		// A high group write during a low group walk makes it a twelve pin walk
		if (start) begin
			if (start_hi && st_d != SQ_IDLE && last_d == PIN_LAST_LO) begin
				last_d = PIN_LAST_HI;
				all_d = 1'b1;
			end else begin
				st_d = SQ_TRI;
				cnt_d = CW'(TRI_CYC);
				pin_d = start_hi ? PIN_FIRST_HI : PIN_FIRST_LO;
				last_d = start_hi ? PIN_LAST_HI : PIN_LAST_LO;
				all_d = 1'b0;
			end
		end
	end

	// Registers of the pin walk
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_q <= SQ_IDLE;
			cnt_q <= '0;
			pin_q <= PIN_FIRST_LO;
			last_q <= PIN_LAST_LO;
			all_q <= 1'b0;
			tri_mask <= '0;
			load_mask <= '0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			pin_q <= pin_d;
			last_q <= last_d;
			all_q <= all_d;
			tri_mask <= tri_d;
			load_mask <= load_d;
		end
	end

endmodule
`default_nettype wire

// >>> tb/smpio_host.sv
// SPI host model driving the serial link in mode (0,0) or (1,1)
`timescale 1ns/1ns
`default_nettype none
module smpio_host #(
	parameter int HALF = 6
) (
	// Clock
	input wire logic mclk,
	// Link pins
	output logic sck,
	output logic chip_select_low,
	output logic si,
	input wire logic so_out,
	input wire logic so_oe,
	// Received byte
	output logic [7:0] rx_byte,
	output logic rx_valid
);
	logic so_last = 1'b0;
	logic so_line;
	logic cpol = 1'b0;
	// Released SO shows the inverse of its last level
	always @(posedge mclk) begin
		if (so_oe) begin
			so_last <= so_out;
		end
	end
	assign so_line = so_oe ? so_out : ~so_last;
	// Idle link: SCK still, deselected
	initial begin
		sck = 1'b0;
		chip_select_low = 1'b1;
		si = 1'b0;
		rx_byte = 8'h00;
		rx_valid = 1'b0;
	end
	// Select, then half a period; the first rise comes a full period after select
	task automatic sel();
		@(posedge mclk);
		chip_select_low <= 1'b0;
		repeat (HALF) @(posedge mclk);
	endtask
	// Only a deselect ends a transfer; SI is then inverted
	task automatic desel();
		repeat (HALF) @(posedge mclk);
		chip_select_low <= 1'b1;
		si <= ~si;
		repeat (2 * HALF) @(posedge mclk);
	endtask
	// Mode (1,1) idles SCK high; switched only while deselected
	task automatic mode(input logic p);
		@(posedge mclk);
		cpol = p;
		sck <= p;
		repeat (HALF) @(posedge mclk);
	endtask
	// One byte MSB first: SI set while SCK low, SO taken at the rise
	task automatic xfer(input logic [7:0] b, input logic c);
		logic [7:0] v;
		for (int i = 7; i >= 0; i--) begin
			if (cpol) begin
				sck <= 1'b0;
			end
			si <= b[i];
			repeat (HALF) @(posedge mclk);
			sck <= 1'b1;
			v[i] = so_line;
			repeat (HALF) @(posedge mclk);
			if (!cpol) begin
				sck <= 1'b0;
			end
		end
		if (c) begin
			rx_byte <= v;
			rx_valid <= 1'b1;
			@(posedge mclk);
			rx_valid <= 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// >>> tb/smpio_spi_slave_chk.sv
// Checker: timing relations at the ports of the SPI port pin block
`timescale 1ns/1ns
`default_nettype none
module smpio_chk import smpio_pkg::*; #(
	parameter int POIP_NS = POIP_NS_DEF
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Link
	input wire logic sck,
	input wire logic chip_select_low,
	input wire logic so_out,
	input wire logic so_oe,
	// Pins and state
	input wire logic [11:0] port_pin_out,
	input wire logic [11:0] port_pin_oe,
	input wire logic write_enable,
	input wire logic high_current_mode,
	input wire logic init_busy
);
	localparam int INIT_MAX = POIP_NS / CLK_NS + 3;
	int init_cnt_q;
	int init_cnt_d;
	// Length of the current init phase
	always_comb begin
		init_cnt_d = init_busy ? init_cnt_q + 1 : 0;
	end
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			init_cnt_q <= 0;
		end else begin
			init_cnt_q <= init_cnt_d;
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_init_tri: assert property (init_busy |-> port_pin_oe == 12'h000)
		else $error("pin driven during init");
	a_init_len: assert property (init_cnt_q <= INIT_MAX)
		else $error("init phase too long");
	a_so_idle: assert property (chip_select_low [*8] |-> !so_oe)
		else $error("SO driven while deselected");
	a_so_start: assert property ($rose(so_oe) |-> !chip_select_low && $past(!chip_select_low, 4))
		else $error("SO enabled outside a frame");
	a_so_fall: assert property ($changed(so_out) |-> !sck && $past(!sck, 2))
		else $error("SO changed away from SCK fall");
	a_we_sel: assert property ($rose(write_enable) |-> $past(!chip_select_low, 3))
		else $error("write enable set outside a frame");
	a_hc_one: assert property (high_current_mode && $past(high_current_mode) && !init_busy
		|-> $countones($past(port_pin_oe) & ~port_pin_oe) <= 1)
		else $error("several pins tristated at once");
	a_lc_group: assert property (!high_current_mode && !init_busy && !$past(init_busy) && $changed(port_pin_out)
		|=> $stable(port_pin_out) [*8])
		else $error("low-current group changed piecemeal");
	c_read: cover property ($rose(so_oe));
	c_we_clr: cover property ($fell(write_enable));
	c_hc: cover property ($rose(high_current_mode));
endmodule
bind smpio_spi_slave smpio_chk #(.POIP_NS(POIP_NS)) u_chk (.mclk(mclk), .rst(rst), .sck(sck),
	.chip_select_low(chip_select_low), .so_out(so_out), .so_oe(so_oe), .port_pin_out(port_pin_out),
	.port_pin_oe(port_pin_oe), .write_enable(write_enable), .high_current_mode(high_current_mode),
	.init_busy(init_busy));
`default_nettype wire

// >>> tb/test_smpio_spi_slave.sv
// Testbench for the SPI memory read and port pin block
`timescale 1ns/1ns
`default_nettype none
module test_smpio_spi_slave import smpio_pkg::*; ();
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic sck, csl, si, so_out, so_oe, we, hcm, ib, rxv;
	logic [11:0] pin_ext, pin_in, pout, poe, p0;
	logic [7:0] stat, mdat, rxb, st;
	logic [55:0] rtc, r0;
	logic [8:0] maddr;
	smpio_cfg_t dflt;
	logic [7:0] expq[$];
	int seed = 32'hE25F;
	int bad_count = 0;
	int n_checks = 0;
	// Clock, pin wire levels, memory behind the block
	always #25 mclk = ~mclk;
	assign pin_in = (poe & pout) | (~poe & pin_ext);
	assign mdat = maddr[7:0] ^ 8'h5A;
	smpio_spi_slave #(.POIP_NS(100)) DUT (.mclk(mclk), .rst(rst), .sck(sck), .chip_select_low(csl),
		.si(si), .so_out(so_out), .so_oe(so_oe), .port_pin_in(pin_in), .port_pin_out(pout),
		.port_pin_oe(poe), .pin_defaults(dflt), .status_in(stat), .rtc_live(rtc), .mem_rd_addr(maddr),
		.mem_rd_data(mdat), .write_enable(we), .high_current_mode(hcm), .init_busy(ib));
	smpio_host #(.HALF(6)) u_host (.mclk(mclk), .sck(sck), .chip_select_low(csl), .si(si),
		.so_out(so_out), .so_oe(so_oe), .rx_byte(rxb), .rx_valid(rxv));
	// Comparison and report
	task automatic note(input logic [11:0] g, input logic [11:0] e);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic ck8(input logic [7:0] g, input logic [7:0] e);
		note({4'h0, g}, {4'h0, e});
	endtask
	task automatic ck12(input logic [11:0] g, input logic [11:0] e);
		note(g, e);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Frames: command only, read, write
	task automatic cmd(input logic [7:0] op);
		u_host.sel();
		u_host.xfer(op, 1'b0);
		u_host.desel();
	endtask
	task automatic rd(input logic [7:0] op, input logic [7:0] ad, input int n);
		u_host.sel();
		u_host.xfer(op, 1'b0);
		u_host.xfer(ad, 1'b0);
		for (int i = 0; i < n; i++) begin
			u_host.xfer(8'h00, 1'b1);
		end
		u_host.desel();
	endtask
	task automatic wr(input logic [7:0] op, input logic [7:0] ad, input logic [23:0] d, input int n);
		u_host.sel();
		u_host.xfer(op, 1'b0);
		u_host.xfer(ad, 1'b0);
		for (int i = 0; i < n; i++) begin
			u_host.xfer(d[23 - 8 * i -: 8], 1'b0);
		end
		u_host.desel();
	endtask
	// Oldest noted byte against each received byte
	always @(posedge mclk) begin
		if (rxv) begin
			ck8(rxb, expq.pop_front());
		end
	end
	// Hang guard
	initial begin
		repeat (30000) @(posedge mclk);
		bad_count++;
		end_sim();
	end
	// Main sequence
	initial begin
		dflt.state = 12'($random(seed));
		dflt.dir = 12'($random(seed));
		dflt.odrain = 12'h000;
		dflt.hcm = 1'b0;
		dflt.rd_inv = 1'b0;
		pin_ext = 12'($random(seed));
		stat = 8'($random(seed));
		rtc = {32'($random(seed)), 24'($random(seed))};
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		repeat (10) @(posedge mclk);
		@(negedge mclk);
		ck12(poe, dflt.dir);
		ck12(pout & dflt.dir, dflt.state & dflt.dir);
		$display("init test done");
		// Reads: map top and wrap, empty space, reserved, clock snapshot, pins
		st = {stat[7:2], 1'b0, stat[0]};
		expq = '{st, 8'h34 ^ 8'h5A, 8'h35 ^ 8'h5A, 8'h5A};
		rd(8'h0B, 8'h34, 4);
		expq = '{st, 8'h00, 8'h00, 8'h5A};
		rd(8'h0B, 8'hFE, 4);
		r0 = rtc;
		expq = '{st, 8'h00, r0[7:0], r0[15:8]};
		fork
			rd(8'h0B, 8'h28, 4);
			begin
				repeat (300) @(posedge mclk);
				rtc <= ~rtc;
			end
		join
		p0 = pin_in;
		expq = '{st, p0[7:0], {4'h0, p0[11:8]}, p0[7:0], {4'h0, p0[11:8]}};
		rd(8'h0B, 8'h26, 5);
		$display("read tests done");
		// Writes: refused, direction, grouped states, status write
		p0 = pout;
		wr(8'h0A, 8'h20, 24'hA50000, 1);
		@(negedge mclk);
		ck12(pout, p0);
		cmd(OPC_WENA);
		wr(8'h0A, 8'h22, 24'hFF0F00, 2);
		@(negedge mclk);
		ck8({7'h00, we}, 8'h00);
		cmd(OPC_WENA);
		wr(8'h0A, 8'h20, 24'hA5035A, 3);
		@(negedge mclk);
		ck12(pout, 12'h35A);
		ck12(poe, 12'hFFF);
		// Mode (1,1): last byte has no trailing fall, lands at deselect
		u_host.mode(1'b1);
		cmd(OPC_WENA);
		wr(8'h0A, 8'h21, 24'h090000, 1);
		@(negedge mclk);
		ck12(pout, 12'h95A);
		u_host.mode(1'b0);
		wr(OPC_STWR, 8'h00, 24'h000000, 0);
		expq = '{st, 8'h5A};
		rd(8'h03, 8'h20, 2);
		cmd(OPC_WDIS);
		$display("write tests done");
		// High-current walk over all twelve pins, then refresh
		cmd(OPC_WENA);
		wr(8'h0A, 8'h25, 24'h010000, 1);
		@(negedge mclk);
		ck8({7'h00, hcm}, 8'h01);
		cmd(OPC_WENA);
		wr(8'h0A, 8'h20, 24'h0F0C00, 2);
		repeat (700) @(posedge mclk);
		@(negedge mclk);
		ck12(pout, 12'hC0F);
		cmd(OPC_RSTR);
		repeat (20) @(posedge mclk);
		@(negedge mclk);
		ck12(poe, dflt.dir);
		$display("high-current and refresh tests done");
		end_sim();
	end
endmodule
`default_nettype wire
